// ### hdl/gbl_pkg.sv
// Summary of operation
// - each logic output is either bus-driven directly or driven by its logic block
// - logic result is the OR of at most two AND terms over chosen inputs
// - AND terms take the first 8 logic outputs, logic inputs and rail flags
// - each AND term picks one rail-status type and any subset of rails
// - sticky flags hold until bus clear or the clear-source input asserts
// - delay applies on assertion, deassertion, both or neither
// - normal delay: a change that reverts before expiry never reaches the pin
// - ignore-inputs option: change always reaches pin after the full delay
// - state-machine mode: path 0 while result true, path 1 while false
// - each special input function is bound to at most one input pin
// - deassertion of the timeout-source input is flagged as a fault
// - margin-enable input puts all margin-enabled rails into margining
// - margin-low select: asserted gives margin low, deasserted margin high
// - input polarity selectable; first 3 defined inputs drive rail-state select
// - any output serves as rail enable, either polarity, open-drain or push-pull
// - in reset pins float except fast pulse pins, which drive low
// - slave starts on master good; master drops good when sequence-off begins
// - a good output may follow any chosen subset of rail-good flags
// - fast pulse outputs share frequency in pairs 1-2, 3-4, 5-6, 7-8
// - enabling one fast pulse output enables its unused partner too
// - fast pulse frequency is 250 MHz divided by 2 to 2^14-1
// - duty step is one sixteenth of a base clock period; the pin resolves whole clocks only
package gbl_pkg;
   localparam int NOUT  = 12;
   localparam int NIN   = 8;
   localparam int NRAIL = 12;
   localparam int NFAST = 8;
   localparam int NPAIR = 4;
   localparam int NTERM_OUT = 8;
   localparam int NSEL  = 3;
   localparam int NTYPE = 8;
   localparam int AW    = 8;
   localparam int DIVW  = 14;
   localparam int DUTYW = 18;
   localparam int DLYW  = 8;
   localparam int TICK_W = 18;
   localparam int CLK_MHZ = 250;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam logic [DIVW-1:0] MIN_DIV = 14'h0002;
   localparam logic [AW-1:0] CFG_BASE  = 8'h00;
   localparam logic [AW-1:0] P0_BASE   = 8'h40;
   localparam logic [AW-1:0] P1_BASE   = 8'h80;
   localparam logic [AW-1:0] CTL_OFF   = 8'hc0;
   localparam logic [AW-1:0] SFN_OFF   = 8'hc4;
   localparam logic [AW-1:0] CLR_OFF   = 8'hc8;
   localparam logic [AW-1:0] STS_OFF   = 8'hcc;
   localparam logic [AW-1:0] DIV_BASE  = 8'hd0;
   localparam logic [AW-1:0] DUTY_BASE = 8'he0;
   localparam logic [AW-1:0] BLK_SPAN  = 8'h30;
   localparam logic [31:0] REG_RST = 32'h0000_0000;
   localparam logic [1:0] RESP_OK = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   localparam int CF_MAN = 0, CF_VAL = 1, CF_SM = 2, CF_DA = 3, CF_DD = 4;
   localparam int CF_IGN = 5, CF_POL = 6, CF_OD = 7, CF_DLY = 8;
   localparam int CF_PWM = 16, CF_USED = 17, CF_CASC = 18;
   localparam int PA_OUT = 0, PA_IN = 8, PA_TYP = 16, PA_STEN = 19, PA_RAIL = 20;
   localparam int CT_POL = 0, CT_DEF = 8, CT_MRG = 16;
   localparam int SF_TMO = 0, SF_CLR = 8, SF_MEN = 16, SF_MLO = 24, SF_EN = 3;
   localparam int CL_TMO = 31;
endpackage : gbl_pkg

// ### hdl/gbl_top.sv
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module gbl_top import gbl_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [AW-1:0]    s_axi_awaddr,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   output logic [1:0]            s_axi_bresp,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   input  wire logic [AW-1:0]    s_axi_araddr,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   input  wire logic [NIN-1:0]   logic_input_pin,
   input  wire logic             bus_control_input,
   input  wire logic [NRAIL-1:0] rail_good,
   input  wire logic [NRAIL-1:0] rail_fault,
   input  wire logic [NRAIL-1:0] rail_warn,
   input  wire logic [NRAIL-1:0] rail_timeout,
   input  wire logic             seq_off_begin,
   output logic [NOUT-1:0]       logic_output_out,
   output logic [NOUT-1:0]       logic_output_oe_n,
   output logic [NSEL-1:0]       rail_state_sel,
   output logic [NRAIL-1:0]      rail_margin_en,
   output logic [NRAIL-1:0]      rail_margin_low,
   output logic                  seq_timeout_fault,
   output logic                  slave_start
);

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         if (s[b]) r[8*b+:8] = n[8*b+:8];
      end
      return r;
   endfunction : merge

   function automatic logic addr_ok(input logic [AW-1:0] a);
      return (a < CFG_BASE + BLK_SPAN) || (a >= P0_BASE && a < P0_BASE + BLK_SPAN) ||
             (a >= P1_BASE && a < P1_BASE + BLK_SPAN) || (a >= CTL_OFF);
   endfunction : addr_ok

   // one pin per special function: the field holds a single pin index
   function automatic logic sfn_hit(input logic [7:0] f, input logic [NIN-1:0] act);
      return f[SF_EN] & act[f[2:0]];
   endfunction : sfn_hit

   function automatic logic and_term(input logic [31:0] p, input logic [NTERM_OUT-1:0] o,
                                     input logic [NIN-1:0] i, input logic [NRAIL-1:0] st);
      logic [NRAIL-1:0] rm;
      logic             any;
      rm  = p[PA_STEN] ? p[PA_RAIL+:NRAIL] : '0;
      any = |{p[PA_OUT+:NTERM_OUT], p[PA_IN+:NIN], rm};
      // an empty term is false so an unused path never asserts the output
      return any & (&(~p[PA_OUT+:NTERM_OUT] | o)) & (&(~p[PA_IN+:NIN] | i))
             & (&(~rm | st));
   endfunction : and_term

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0]       cfg_reg [NOUT];
   logic [31:0]       p0_reg [NOUT];
   logic [31:0]       p1_reg [NOUT];
   logic [31:0]       ctl_reg, sfn_reg;
   logic [DIVW-1:0]   div_reg [NPAIR];
   logic [DUTYW-1:0]  duty_reg [NFAST];
   logic [AW-1:0]     aw_addr_reg, ar_addr;
   logic [31:0]       w_data_reg;
   logic [3:0]        w_strb_reg;
   logic              aw_full_reg, w_full_reg, aw_full_next, w_full_next;
   logic              awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0]        bresp_reg, rresp_reg;
   logic [31:0]       rdata_reg, rd_data;
   logic              aw_hs, w_hs, ar_hs, do_wr, rvalid_next;
   logic [NIN-1:0]    in_s1_reg, in_s2_reg, in_act_d_reg;
   logic              bc_s1_reg, bc_s2_reg;
   wire  [NIN-1:0]    in_act = in_s2_reg ^ ~ctl_reg[CT_POL+:NIN];
   logic [TICK_W-1:0] tick_cnt_reg;
   wire               tick = (tick_cnt_reg == '0);
   logic [NRAIL-1:0]  lat_reg [NPAIR];
   wire  [NRAIL-1:0]  all_st [NTYPE];
   logic [NOUT-1:0]   lval, res_reg, filt_reg, pend_reg, pend_val_reg, pwm_on, pwm_bit;
   logic [DLYW-1:0]   dcnt_reg [NOUT];
   logic [DIVW-1:0]   pcnt_reg [NPAIR];
   logic [NOUT-1:0]   out_reg, oe_n_reg;
   logic [NSEL-1:0]   rs_next, rs_reg;
   logic [NRAIL-1:0]  men_reg, mlo_reg;
   logic              tmo_reg, bc_reg;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: address and data are taken independently, write on both
   assign aw_hs        = s_axi_awvalid & awready_reg;
   assign w_hs         = s_axi_wvalid & wready_reg;
   assign do_wr        = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign aw_full_next = (aw_full_reg | aw_hs) & ~do_wr;
   assign w_full_next  = (w_full_reg | w_hs) & ~do_wr;
   assign ar_hs        = s_axi_arvalid & arready_reg;
   assign ar_addr      = s_axi_araddr;
   assign rvalid_next  = (rvalid_reg & ~s_axi_rready) | ar_hs;
   wire   wr_ctl       = do_wr && aw_addr_reg[AW-1:2] == CTL_OFF[AW-1:2];
   wire   wr_sfn       = do_wr && aw_addr_reg[AW-1:2] == SFN_OFF[AW-1:2];
   wire   wr_clr       = do_wr && aw_addr_reg[AW-1:2] == CLR_OFF[AW-1:2];
   wire   [31:0] clr_w = wr_clr ? merge(REG_RST, w_data_reg, w_strb_reg) : REG_RST;

   always_ff @(posedge clock) begin
      if (srst) begin
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OK;
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= RESP_OK;
         rdata_reg   <= REG_RST;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg  <= w_full_next;
         awready_reg <= ~aw_full_next;
         wready_reg  <= ~w_full_next;
         if (do_wr) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= addr_ok(aw_addr_reg) ? RESP_OK : RESP_ERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
         rvalid_reg  <= rvalid_next;
         arready_reg <= ~rvalid_next;
         if (ar_hs) begin
            rdata_reg <= rd_data;
            rresp_reg <= addr_ok(ar_addr) ? RESP_OK : RESP_ERR;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (aw_hs) aw_addr_reg <= s_axi_awaddr;
      if (w_hs) begin
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
   end

   always_comb begin
      rd_data = REG_RST;
      if (ar_addr < CFG_BASE + BLK_SPAN) rd_data = cfg_reg[ar_addr[5:2]];
      else if (ar_addr >= P0_BASE && ar_addr < P0_BASE + BLK_SPAN) rd_data = p0_reg[ar_addr[5:2]];
      else if (ar_addr >= P1_BASE && ar_addr < P1_BASE + BLK_SPAN) rd_data = p1_reg[ar_addr[5:2]];
      else if (ar_addr[AW-1:2] == CTL_OFF[AW-1:2]) rd_data = ctl_reg;
      else if (ar_addr[AW-1:2] == SFN_OFF[AW-1:2]) rd_data = sfn_reg;
      else if (ar_addr[AW-1:2] == STS_OFF[AW-1:2]) rd_data = {11'h0, tmo_reg, in_act, lval};
      else if (ar_addr >= DUTY_BASE) rd_data = {14'h0, duty_reg[ar_addr[4:2]]};
      else if (ar_addr >= DIV_BASE) rd_data = {18'h0, div_reg[ar_addr[3:2]]};
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ctl_reg <= REG_RST;
         sfn_reg <= REG_RST;
      end else begin
         if (wr_ctl) ctl_reg <= merge(ctl_reg, w_data_reg, w_strb_reg);
         if (wr_sfn) sfn_reg <= merge(sfn_reg, w_data_reg, w_strb_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins from outside are synchronised; only the second stage is used
   always_ff @(posedge clock) begin
      in_s1_reg <= logic_input_pin;
      in_s2_reg <= in_s1_reg;
      bc_s1_reg <= bus_control_input;
      bc_s2_reg <= bc_s1_reg;
   end

   wire tmo_fall = sfn_hit(sfn_reg[SF_TMO+:8], in_act_d_reg) & ~sfn_hit(sfn_reg[SF_TMO+:8], in_act);
   wire clr_rise = sfn_hit(sfn_reg[SF_CLR+:8], in_act) & ~sfn_hit(sfn_reg[SF_CLR+:8], in_act_d_reg);
   wire men      = sfn_hit(sfn_reg[SF_MEN+:8], in_act);
   wire mlo      = sfn_hit(sfn_reg[SF_MLO+:8], in_act);

   always_comb begin
      int k;
      k = 0;
      rs_next = '0;
      for (int i = 0; i < NIN; i++) begin
         if (ctl_reg[CT_DEF+i] && k < NSEL) begin
            rs_next[k] = in_act[i];
            k = k + 1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         in_act_d_reg <= '0;
         tick_cnt_reg <= '0;
         tmo_reg      <= 1'b0;
         rs_reg       <= '0;
         men_reg      <= '0;
         mlo_reg      <= '0;
         bc_reg       <= 1'b0;
      end else begin
         in_act_d_reg <= in_act;
         tick_cnt_reg <= tick ? TICK_W'(TICK_CYCLES - 1) : tick_cnt_reg - 1'b1;
         // a new fault in the clearing cycle keeps the flag set
         tmo_reg      <= tmo_fall | (tmo_reg & ~clr_w[CL_TMO]);
         rs_reg       <= rs_next;
         men_reg      <= {NRAIL{men}} & ctl_reg[CT_MRG+:NRAIL];
         mlo_reg      <= {NRAIL{men & mlo}} & ctl_reg[CT_MRG+:NRAIL];
         bc_reg       <= bc_s2_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // types 0-3 are live, 4-7 their sticky copies
   for (genvar t = 0; t < NPAIR; t++) begin : g_lat
      wire [NRAIL-1:0] live = (t == 0) ? rail_good : (t == 1) ? rail_fault :
                              (t == 2) ? rail_warn : rail_timeout;
      assign all_st[t]         = live;
      assign all_st[t + NPAIR] = lat_reg[t];
      always_ff @(posedge clock) begin
         if (srst) lat_reg[t] <= '0;
         else lat_reg[t] <= live | (lat_reg[t] & ~{NRAIL{clr_rise | clr_w[t]}});
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      wire [DIVW-1:0] div = (div_reg[p] < MIN_DIV) ? MIN_DIV : div_reg[p];
      wire wr_div = do_wr && aw_addr_reg[AW-1:2] == DIV_BASE[AW-1:2] + 6'(p);
      always_ff @(posedge clock) begin
         if (srst) begin
            div_reg[p]  <= MIN_DIV;
            pcnt_reg[p] <= '0;
         end else begin
            if (wr_div) div_reg[p] <= DIVW'(merge({18'h0, div_reg[p]}, w_data_reg, w_strb_reg));
            // one counter per pair: both pins share the period
            pcnt_reg[p] <= (pcnt_reg[p] >= div - 1'b1) ? '0 : pcnt_reg[p] + 1'b1;
         end
      end
   end

   for (genvar f = 0; f < NOUT; f++) begin : g_fast
      if (f < NFAST) begin : g_on
         wire wr_duty = do_wr && aw_addr_reg[AW-1:2] == DUTY_BASE[AW-1:2] + 6'(f);
         // duty is in sixteenths of a clock; the pin resolves whole clocks only
         assign pwm_bit[f] = {pcnt_reg[f/2], 4'h0} < duty_reg[f];
         assign pwm_on[f]  = cfg_reg[f][CF_PWM] |
                             (cfg_reg[f^1][CF_PWM] & ~cfg_reg[f][CF_USED]);
         always_ff @(posedge clock) begin
            if (srst) duty_reg[f] <= '0;
            else if (wr_duty) duty_reg[f] <= DUTYW'(merge({14'h0, duty_reg[f]}, w_data_reg,
                                                          w_strb_reg));
         end
      end else begin : g_off
         assign pwm_bit[f] = 1'b0;
         assign pwm_on[f]  = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   for (genvar g = 0; g < NOUT; g++) begin : g_out
      wire [31:0] cf = cfg_reg[g];
      wire [31:0] q0 = p0_reg[g];
      wire [31:0] q1 = p1_reg[g];
      wire t0 = and_term(q0, lval[NTERM_OUT-1:0], in_act, all_st[q0[PA_TYP+:3]]);
      wire t1 = and_term(q1, lval[NTERM_OUT-1:0], in_act, all_st[q1[PA_TYP+:3]]);
      wire res_next = cf[CF_SM] ? (res_reg[g] ? t0 : t1) : (t0 | t1);
      wire stop     = cf[CF_CASC] & seq_off_begin;
      wire need_dly = (res_reg[g] ? cf[CF_DA] : cf[CF_DD]) && cf[CF_DLY+:DLYW] != '0;
      wire pend_done = tick && dcnt_reg[g] == '0;
      wire pv = lval[g] ~^ cf[CF_POL];
      wire wr_cfg = do_wr && aw_addr_reg[AW-1:2] == CFG_BASE[AW-1:2] + 6'(g);
      wire wr_p0  = do_wr && aw_addr_reg[AW-1:2] == P0_BASE[AW-1:2] + 6'(g);
      wire wr_p1  = do_wr && aw_addr_reg[AW-1:2] == P1_BASE[AW-1:2] + 6'(g);
      assign lval[g] = cf[CF_MAN] ? cf[CF_VAL] : filt_reg[g];

      always_ff @(posedge clock) begin
         if (srst) begin
            cfg_reg[g] <= REG_RST;
            p0_reg[g]  <= REG_RST;
            p1_reg[g]  <= REG_RST;
         end else begin
            if (wr_cfg) cfg_reg[g] <= merge(cf, w_data_reg, w_strb_reg);
            if (wr_p0) p0_reg[g] <= merge(q0, w_data_reg, w_strb_reg);
            if (wr_p1) p1_reg[g] <= merge(q1, w_data_reg, w_strb_reg);
         end
      end

      always_ff @(posedge clock) begin
         if (srst) begin
            res_reg[g]      <= 1'b0;
            filt_reg[g]     <= 1'b0;
            pend_reg[g]     <= 1'b0;
            pend_val_reg[g] <= 1'b0;
            dcnt_reg[g]     <= '0;
         end else begin
            res_reg[g] <= res_next & ~stop;
            if (stop) begin
               filt_reg[g] <= 1'b0;
               pend_reg[g] <= 1'b0;
            end else if (pend_reg[g]) begin
               if (!cf[CF_IGN] && res_reg[g] == filt_reg[g]) begin
                  pend_reg[g] <= 1'b0;
               end else if (pend_done) begin
                  filt_reg[g] <= pend_val_reg[g];
                  pend_reg[g] <= 1'b0;
               end else if (tick) begin
                  dcnt_reg[g] <= dcnt_reg[g] - 1'b1;
               end
            end else if (res_reg[g] != filt_reg[g]) begin
               if (need_dly) begin
                  pend_reg[g]     <= 1'b1;
                  pend_val_reg[g] <= res_reg[g];
                  dcnt_reg[g]     <= cf[CF_DLY+:DLYW] - 1'b1;
               end else begin
                  filt_reg[g] <= res_reg[g];
               end
            end
         end
      end

      // fast pins drive low in reset and while unused and not pulsing, others float
      always_ff @(posedge clock) begin
         if (srst) begin
            out_reg[g]  <= 1'b0;
            oe_n_reg[g] <= (g < NFAST) ? 1'b0 : 1'b1;
         end else if (pwm_on[g]) begin
            out_reg[g]  <= pwm_bit[g];
            oe_n_reg[g] <= 1'b0;
         end else if (!cf[CF_USED]) begin
            out_reg[g]  <= 1'b0;
            oe_n_reg[g] <= (g < NFAST) ? 1'b0 : 1'b1;
         end else begin
            out_reg[g]  <= pv;
            oe_n_reg[g] <= cf[CF_OD] & pv;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign s_axi_awready     = awready_reg;
   assign s_axi_wready      = wready_reg;
   assign s_axi_bvalid      = bvalid_reg;
   assign s_axi_bresp       = bresp_reg;
   assign s_axi_arready     = arready_reg;
   assign s_axi_rvalid      = rvalid_reg;
   assign s_axi_rdata       = rdata_reg;
   assign s_axi_rresp       = rresp_reg;
   assign logic_output_out  = out_reg;
   assign logic_output_oe_n = oe_n_reg;
   assign rail_state_sel    = rs_reg;
   assign rail_margin_en    = men_reg;
   assign rail_margin_low   = mlo_reg;
   assign seq_timeout_fault = tmo_reg;
   assign slave_start       = bc_reg;

endmodule : gbl_top
`default_nettype wire

// ### verif/gbl_rail_model.sv
`timescale 1ns/1ps
`default_nettype none
module gbl_rail_model import gbl_pkg::*; (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic [NRAIL-1:0] rail_up,
   input  wire logic [NRAIL-1:0] rail_hit,
   output logic [NRAIL-1:0]      rail_good,
   output logic [NRAIL-1:0]      rail_fault,
   output logic [NRAIL-1:0]      rail_warn,
   output logic [NRAIL-1:0]      rail_timeout,
   output logic                  bus_control_input
);
   // rails settle one cycle after enable; master good needs every rail
   always_ff @(posedge clock) begin
      rail_good <= srst ? 12'h000 : rail_up;
      bus_control_input <= !srst && (&rail_good);
   end
   assign rail_fault = rail_hit;
   assign rail_warn = rail_hit & rail_good;
   assign rail_timeout = rail_up & ~rail_good;
endmodule : gbl_rail_model
`default_nettype wire

// ### verif/gbl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module gbl_chk import gbl_pkg::*; (
   input wire logic            clock,
   input wire logic            srst,
   input wire logic            s_axi_awready,
   input wire logic            s_axi_bvalid,
   input wire logic            s_axi_bready,
   input wire logic [1:0]      s_axi_bresp,
   input wire logic            s_axi_arvalid,
   input wire logic            s_axi_arready,
   input wire logic            s_axi_rvalid,
   input wire logic            s_axi_rready,
   input wire logic [31:0]     s_axi_rdata,
   input wire logic            bus_control_input,
   input wire logic [NOUT-1:0] logic_output_out,
   input wire logic [NOUT-1:0] logic_output_oe_n,
   input wire logic [NRAIL-1:0] rail_margin_en,
   input wire logic [NRAIL-1:0] rail_margin_low,
   input wire logic            seq_timeout_fault,
   input wire logic            slave_start
);
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   chk_reset_pins: assert property (
      $fell(srst) |-> logic_output_oe_n == 12'hf00 && logic_output_out == 12'h000)
      else $error("pins left reset state early");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("address taken during read answer");
   chk_aw_reopen: assert property ($rose(s_axi_bvalid) |-> s_axi_awready)
      else $error("address not reopened with write answer");
   chk_margin_sub: assert property (
      (rail_margin_low & ~rail_margin_en) == 12'h000) else $error("low without margin");
   chk_slave_on: assert property (
      bus_control_input [*5] |-> slave_start) else $error("slave start missing");
   chk_slave_off: assert property (
      !bus_control_input [*5] |-> !slave_start) else $error("slave start stuck");
   chk_fault_clear: assert property (
      $fell(seq_timeout_fault) && !$past(srst) |-> $rose(s_axi_bvalid))
      else $error("fault cleared without write");
endmodule : gbl_chk
bind gbl_top gbl_chk u_chk (.*);
`default_nettype wire

// ### verif/gbl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module gbl_bench import gbl_pkg::*;;
   logic clock = 1'b0, srst = 1'b1, seq_off_begin = 1'b0, bus_control_input;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, seq_timeout_fault, slave_start;
   logic [AW-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, a;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, seen, h2, h3;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, st;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp, p;
   logic [NIN-1:0] logic_input_pin = 8'h00;
   logic [NRAIL-1:0] rail_good, rail_fault, rail_warn, rail_timeout, rail_margin_en;
   logic [NRAIL-1:0] rail_up = 12'h000, rail_hit = 12'h000, rail_margin_low;
   logic [NOUT-1:0] logic_output_out, logic_output_oe_n;
   logic [NSEL-1:0] rail_state_sel;
   logic [31:0] dir [3] = '{32'h0002_0043, 32'h0002_00c3, 32'h0002_0041};
   int n_errors = 0, checks_done = 0, cycles = 0, seed = 32'ha087;
   logic [31:0] model [int];
   // 4-cycle tick keeps millisecond delays short in simulation
   gbl_top #(.TICK_CYCLES(4)) uut (.*);
   gbl_rail_model part (.*);
   initial forever #2 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   task stop_test();
      if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   task cyc(input int n);
      repeat (n) @(posedge clock);
   endtask : cyc
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic [7:0] wa, input logic [31:0] d);
      logic aw_d, w_d;
      aw_d = 1'b0;
      w_d = 1'b0;
      s_axi_awaddr <= wa;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw_d && w_d)) begin
         @(posedge clock);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_awready === 1'b1) aw_d = 1'b1;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         if (s_axi_wready === 1'b1) w_d = 1'b1;
      end
      s_axi_bready <= 1'b1;
      do @(posedge clock); while (s_axi_bvalid !== 1'b1);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      model[wa] = d;
   endtask : wr
   task rdt(input logic [7:0] ra, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= ra;
      s_axi_arvalid <= 1'b1;
      do @(posedge clock); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      do @(posedge clock); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(32'(s_axi_rresp), 32'(er));
   endtask : rdt
   ////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      chk(32'(logic_output_oe_n), 32'h0000_0f00);
      chk(32'(logic_output_out), 32'h0);
      for (int i = 0; i < 24; i++) begin
         a = (i < 12) ? P0_BASE + 8'(4 * i) : P1_BASE + 8'(4 * (i - 12));
         wr(a, $random(seed));
         rdt(a, model[a], RESP_OK);
         wr(a, 32'h0);
      end
      rdt(8'h30, 32'h0, RESP_ERR);
      wr(8'h30, 32'hffff_ffff);
      chk(32'(rsp), 32'(RESP_ERR));
      v = $random(seed) & 32'h0000_0fff;
      wr(CTL_OFF, {4'h0, v[11:0], 16'h0e0f});
      for (int i = 0; i < 3; i++) begin
         wr(8'h2c, dir[i]);
         cyc(6);
         chk(32'(logic_output_out[11]), 32'(dir[i][1]));
         chk(32'(logic_output_oe_n[11]), 32'(dir[i][7] & dir[i][1]));
      end
      wr(P0_BASE, 32'h0000_0100);
      wr(P1_BASE, 32'h0000_0200);
      wr(CFG_BASE, 32'h0002_0040);
      for (int i = 0; i < 16; i++) begin
         p = 2'($random(seed));
         // 2'b10 would flip a state-machine result every cycle
         if (i >= 7 && p == 2'b10) p = 2'b11;
         if (i == 8) wr(CFG_BASE, 32'h0002_0044);
         logic_input_pin[1:0] <= p;
         cyc(10);
         st = (i < 8) ? |p : (st ? p[0] : p[1]);
         chk(32'(logic_output_out[0]), 32'(st));
      end
      logic_input_pin <= 8'h00;
      for (int m = 0; m < 2; m++) begin
         wr(CFG_BASE, m ? 32'h0002_0378 : 32'h0002_0358);
         cyc(40);
         logic_input_pin[0] <= 1'b1;
         cyc(3);
         logic_input_pin[0] <= 1'b0;
         seen = 0;
         repeat (40) @(posedge clock) seen |= logic_output_out[0];
         chk(seen, m);
      end
      wr(SFN_OFF, 32'h0a09_000b);
      logic_input_pin[3:1] <= 3'b111;
      cyc(8);
      chk(32'(rail_margin_en), v);
      chk(32'(rail_margin_low), v);
      chk(32'(rail_state_sel), 32'h7);
      logic_input_pin[3:2] <= 2'b00;
      cyc(8);
      chk(32'(rail_margin_low), 32'h0);
      chk(32'(rail_state_sel), 32'h1);
      chk(32'(seq_timeout_fault), 32'h1);
      wr(CLR_OFF, 32'h8000_0000);
      cyc(2);
      chk(32'(seq_timeout_fault), 32'h0);
      wr(8'h04, 32'h0002_0040);
      wr(8'h44, 32'h001d_0000);
      rail_hit[0] <= 1'b1;
      cyc(2);
      rail_hit[0] <= 1'b0;
      cyc(8);
      chk(32'(logic_output_out[1]), 32'h1);
      wr(CLR_OFF, 32'h0000_000f);
      cyc(8);
      chk(32'(logic_output_out[1]), 32'h0);
      wr(8'h44, 32'h0038_0000);
      rail_up <= 12'h003;
      cyc(8);
      chk(32'(logic_output_out[1]), 32'h1);
      chk(32'(slave_start), 32'h0);
      rail_up <= 12'hfff;
      cyc(10);
      chk(32'(slave_start), 32'h1);
      wr(8'h04, 32'h0006_0040);
      seq_off_begin <= 1'b1;
      cyc(4);
      chk(32'(logic_output_out[1]), 32'h0);
      seq_off_begin <= 1'b0;
      cyc(6);
      chk(32'(logic_output_out[1]), 32'h1);
      // pair 1: only output 2 is set up, output 3 must follow as its partner
      wr(8'h08, 32'h0001_0000);
      wr(DIV_BASE + 8'h04, 32'h5);
      wr(DUTY_BASE + 8'h08, 32'd48);
      wr(DUTY_BASE + 8'h0c, 32'd16);
      cyc(10);
      h2 = 0;
      h3 = 0;
      repeat (40) begin
         @(posedge clock);
         h2 += logic_output_out[2];
         h3 += logic_output_out[3];
      end
      chk(h2, (40 / 5) * (48 / 16));
      chk(h3, (40 / 5) * (16 / 16));
      stop_test();
   end
endmodule : gbl_bench
`default_nettype wire
